/* File: logic/rmedb_unit.sv */
// Real-mode exception, debug trap, halt and shutdown unit.
// Assumes the core stalls while halted or shut down and samples exc_o.
//
// Contract
// RQ1: Breakpoint opcode raises trap vector 3
// RQ2: Single-step flag at retire raises vector 1
// RQ3: Four address and two status/control registers
// RQ4: All breakpoints disabled after reset
// RQ5: Breakpoint register match raises vector 1
// RQ6: Reset into real mode, 16-bit operand default
// RQ7: Physical address is segment shl 4 plus offset
// RQ8: No paging, linear equals physical
// RQ9: Segments 64K long, fully accessible
// RQ10: Offset overrun or word at FFFF gives 13
// RQ11: Stack overrun gives exception 12
// RQ12: Vector beyond table limit gives exception 8
// RQ13: Never raise 10, 11 or 14
// RQ14: Software reserves low memory for vectors
// RQ15: Software reserves top locations for init
// RQ16: Halt held until NMI, float, INTR, reset
// RQ17: Wake pointer addresses instruction after halt
// RQ18: Enter shutdown on vector overrun or odd wrap
// RQ19: NMI leaves shutdown only with room
// RQ20: Illegal atomic prefix form raises vector 6
// RQ21: Legal atomic forms lock, any privilege
//
// Decided for this implementation: the strobed register port and the register offsets.
`default_nettype none

module rmedb_unit (
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic [rmedb_pkg::BUS_AW-1:0] bus_addr_i,
	input wire logic [31:0] bus_wdata_i,
	input wire logic bus_wr_i,
	input wire logic bus_rd_i,
	output logic [31:0] bus_rdata_o,
	input wire rmedb_pkg::rmedb_instr_t instr_i,
	input wire rmedb_pkg::rmedb_mem_t mem_i,
	input wire rmedb_pkg::rmedb_int_t int_i,
	input wire logic [15:0] stack_pointer_i,
	input wire logic nmi_i,
	input wire logic intr_i,
	input wire logic bus_float_n_i,
	output rmedb_pkg::rmedb_exc_t exc_o,
	output logic [rmedb_pkg::PHYS_W-1:0] phys_addr_o,
	output logic halted_o,
	output logic shutdown_o,
	output logic wake_o,
	output logic [15:0] return_code_pointer_o,
	output logic bus_lock_o,
	output logic oper32_o,
	output logic real_mode_o
);
	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic vec_outside(input logic [7:0] v, input logic [15:0] lim);
		return 16'({v, rmedb_pkg::VEC_TAIL}) > lim;
	endfunction

	function automatic logic [rmedb_pkg::PHYS_W-1:0] phys_of(input logic [15:0] seg,
			input logic [31:0] ea);
		return rmedb_pkg::PHYS_W'({seg, rmedb_pkg::SEG_PAD}) + rmedb_pkg::PHYS_W'(ea[15:0]);
	endfunction

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	logic [2:0] pin_s1_reg, pin_s2_reg, pin_s1_next, pin_s2_next;
	logic nmi_prev_reg, nmi_prev_next;
	logic nmi_edge, intr_lvl, float_lvl;

	always_comb begin
		pin_s1_next = {nmi_i, intr_i, ~bus_float_n_i};
		pin_s2_next = pin_s1_reg;
		nmi_prev_next = pin_s2_reg[2];
	end

	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pin_s1_reg <= 3'h0;
			pin_s2_reg <= 3'h0;
			nmi_prev_reg <= 1'b0;
		end else begin
			pin_s1_reg <= pin_s1_next;
			pin_s2_reg <= pin_s2_next;
			nmi_prev_reg <= nmi_prev_next;
		end
	end

	assign nmi_edge = pin_s2_reg[2] & ~nmi_prev_reg;
	assign intr_lvl = pin_s2_reg[1];
	assign float_lvl = pin_s2_reg[0];

	// ****************************************************************
	// Breakpoint matching
	// ****************************************************************
	logic [31:0] bpa_reg [rmedb_pkg::NUM_BP];
	logic [31:0] bpa_next [rmedb_pkg::NUM_BP];
	logic [31:0] bctl_reg, bctl_next, bstat_reg, bstat_next;
	logic [15:0] tlim_reg, tlim_next;
	logic [31:0] rdata_next;
	logic [rmedb_pkg::NUM_BP-1:0] exec_hit, data_hit;
	logic [rmedb_pkg::PHYS_W-1:0] mem_phys;
	rmedb_pkg::rmedb_state_t state_reg, state_next;
	logic run;

	assign run = state_reg == rmedb_pkg::ST_RUN;
	assign mem_phys = phys_of(mem_i.seg_val, mem_i.ea); // RQ7 RQ8

	always_comb begin
		logic [1:0] typ;
		logic [rmedb_pkg::PHYS_W-1:0] a;
		typ = 2'h0;
		a = '0;
		exec_hit = '0;
		data_hit = '0;
		for (int i = 0; i < rmedb_pkg::NUM_BP; i++) begin
			typ = bctl_reg[rmedb_pkg::BCTL_TYPE_LSB + 2*i +: 2];
			a = bpa_reg[i][rmedb_pkg::PHYS_W-1:0];
			if (bctl_reg[i]) begin // RQ4
				exec_hit[i] = instr_i.valid && typ == rmedb_pkg::BPT_EXEC
					&& a == instr_i.lin_addr; // RQ5
				data_hit[i] = mem_i.valid && !mem_i.is_fetch
					&& (typ == rmedb_pkg::BPT_RW || (typ == rmedb_pkg::BPT_WR && mem_i.is_write))
					&& (a == mem_phys
						|| (mem_i.is_word && a == rmedb_pkg::PHYS_W'(mem_phys + 1'b1))); // RQ5
			end
		end
	end

	// ****************************************************************
	// Exception, halt and shutdown control
	// ****************************************************************
	rmedb_pkg::rmedb_exc_t exc_reg, exc_next;
	logic [rmedb_pkg::PHYS_W-1:0] phys_reg, phys_next;
	logic wake_reg, wake_next, lock_reg, lock_next, op32_reg, op32_next;
	logic if_reg, if_next;
	logic [15:0] rcp_reg, rcp_next;
	logic [31:0] stat_set;
	logic seg_over, lock_bad;

	always_comb begin
		exc_next = '0;
		state_next = state_reg;
		phys_next = phys_reg;
		wake_next = 1'b0;
		lock_next = 1'b0;
		op32_next = op32_reg;
		if_next = if_reg;
		rcp_next = rcp_reg;
		stat_set = '0;
		// RQ9 RQ10 RQ11
		seg_over = mem_i.ea > rmedb_pkg::SEG_LIMIT
			|| (mem_i.is_word && mem_i.ea == rmedb_pkg::SEG_LIMIT);
		lock_bad = instr_i.lock && (instr_i.rep || instr_i.lock_cls == rmedb_pkg::LK_OTHER
			|| instr_i.lock_cls == rmedb_pkg::LK_NONE); // RQ20
		case (state_reg)
			rmedb_pkg::ST_RUN: begin
				if (mem_i.valid) begin
					phys_next = mem_phys; // RQ7 RQ8
				end
				if (instr_i.valid) begin
					op32_next = instr_i.opsize_pfx; // RQ6
					lock_next = instr_i.lock && !lock_bad; // RQ21
				end
				stat_set[rmedb_pkg::NUM_BP-1:0] = exec_hit | data_hit; // RQ3
				if (instr_i.valid && instr_i.flags[rmedb_pkg::TF_BIT]) begin
					stat_set[rmedb_pkg::BS_STEP_BIT] = 1'b1;
				end
				// Single-step and data-breakpoint traps come first
				if ((instr_i.valid && instr_i.flags[rmedb_pkg::TF_BIT]) || |data_hit) begin
					exc_next = '{valid: 1'b1, vector: rmedb_pkg::VEC_DEBUG, fault: 1'b0}; // RQ2
				end else if (|exec_hit) begin
					exc_next = '{valid: 1'b1, vector: rmedb_pkg::VEC_DEBUG, fault: 1'b1}; // RQ5
				end else if (mem_i.valid && mem_i.is_push && mem_i.seg == rmedb_pkg::SG_STACK
						&& stack_pointer_i == rmedb_pkg::SP_ONE) begin
					state_next = rmedb_pkg::ST_SHUTDOWN; // RQ18
				end else if (mem_i.valid && seg_over) begin
					exc_next = '{valid: 1'b1, fault: 1'b1,
						vector: mem_i.seg == rmedb_pkg::SG_STACK ? rmedb_pkg::VEC_STACK
							: rmedb_pkg::VEC_GPROT}; // RQ10 RQ11
				end else if (instr_i.valid && lock_bad) begin
					exc_next = '{valid: 1'b1, vector: rmedb_pkg::VEC_INVOP, fault: 1'b1}; // RQ20
				end else if (instr_i.valid && instr_i.opcode == rmedb_pkg::OP_BREAK) begin
					exc_next = '{valid: 1'b1, vector: rmedb_pkg::VEC_BREAK, fault: 1'b0}; // RQ1
				end else if (int_i.valid && vec_outside(int_i.vector, tlim_reg)) begin
					exc_next = '{valid: 1'b1, vector: rmedb_pkg::VEC_DFAULT, fault: 1'b1}; // RQ12
				end else if (instr_i.valid && instr_i.opcode == rmedb_pkg::OP_STOP) begin
					state_next = rmedb_pkg::ST_HALTED; // RQ16
					rcp_next = instr_i.next_ip; // RQ17
					if_next = instr_i.flags[rmedb_pkg::IF_BIT];
				end
				if (exc_next.valid && (exc_next.vector == rmedb_pkg::VEC_DFAULT
						|| exc_next.vector == rmedb_pkg::VEC_GPROT)
						&& vec_outside(exc_next.vector, tlim_reg)) begin
					exc_next = '0;
					state_next = rmedb_pkg::ST_SHUTDOWN; // RQ18
				end
			end
			rmedb_pkg::ST_HALTED: begin
				if (nmi_edge || float_lvl || (intr_lvl && if_reg)) begin
					state_next = rmedb_pkg::ST_RUN; // RQ16
					wake_next = 1'b1; // RQ17
				end
			end
			rmedb_pkg::ST_SHUTDOWN: begin
				if (nmi_edge && tlim_reg >= rmedb_pkg::NMI_LIM_MIN
						&& stack_pointer_i > rmedb_pkg::NMI_SP_MIN) begin
					state_next = rmedb_pkg::ST_RUN; // RQ19
					wake_next = 1'b1;
				end
			end
			default: begin
				state_next = rmedb_pkg::ST_RUN;
			end
		endcase
	end

	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_reg <= rmedb_pkg::ST_RUN; // RQ6
			exc_reg <= '0;
			phys_reg <= '0;
			wake_reg <= 1'b0;
			lock_reg <= 1'b0;
			op32_reg <= 1'b0; // RQ6
			if_reg <= 1'b0;
			rcp_reg <= 16'h0000;
		end else begin
			state_reg <= state_next;
			exc_reg <= exc_next;
			phys_reg <= phys_next;
			wake_reg <= wake_next;
			lock_reg <= lock_next;
			op32_reg <= op32_next;
			if_reg <= if_next;
			rcp_reg <= rcp_next;
		end
	end

	// ****************************************************************
	// Register bus
	// ****************************************************************
	always_comb begin
		for (int i = 0; i < rmedb_pkg::NUM_BP; i++) begin
			bpa_next[i] = bpa_reg[i];
		end
		bctl_next = bctl_reg;
		tlim_next = tlim_reg;
		bstat_next = bstat_reg;
		rdata_next = '0;
		if (bus_wr_i) begin
			case (bus_addr_i)
				rmedb_pkg::REG_BPA0: bpa_next[0] = bus_wdata_i; // RQ3
				rmedb_pkg::REG_BPA1: bpa_next[1] = bus_wdata_i;
				rmedb_pkg::REG_BPA2: bpa_next[2] = bus_wdata_i;
				rmedb_pkg::REG_BPA3: bpa_next[3] = bus_wdata_i;
				rmedb_pkg::REG_BSTAT: bstat_next = bstat_reg & ~bus_wdata_i;
				rmedb_pkg::REG_BCTL: bctl_next = bus_wdata_i;
				rmedb_pkg::REG_TLIM: tlim_next = bus_wdata_i[15:0];
				default: begin
				end
			endcase
		end
		bstat_next = bstat_next | stat_set;
		if (bus_rd_i) begin
			case (bus_addr_i)
				rmedb_pkg::REG_BPA0: rdata_next = bpa_reg[0];
				rmedb_pkg::REG_BPA1: rdata_next = bpa_reg[1];
				rmedb_pkg::REG_BPA2: rdata_next = bpa_reg[2];
				rmedb_pkg::REG_BPA3: rdata_next = bpa_reg[3];
				rmedb_pkg::REG_BSTAT: rdata_next = bstat_reg;
				rmedb_pkg::REG_BCTL: rdata_next = bctl_reg;
				rmedb_pkg::REG_TLIM: rdata_next = {16'h0000, tlim_reg};
				rmedb_pkg::REG_STATE: rdata_next = {28'h0000000, op32_reg, 1'b1,
					state_reg == rmedb_pkg::ST_SHUTDOWN, state_reg == rmedb_pkg::ST_HALTED};
				default: rdata_next = '0;
			endcase
		end
	end

	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			for (int i = 0; i < rmedb_pkg::NUM_BP; i++) begin
				bpa_reg[i] <= 32'h00000000;
			end
			bctl_reg <= rmedb_pkg::BCTL_RST; // RQ4
			bstat_reg <= rmedb_pkg::BSTAT_RST;
			tlim_reg <= rmedb_pkg::TLIM_RST;
			bus_rdata_o <= 32'h00000000;
		end else begin
			for (int i = 0; i < rmedb_pkg::NUM_BP; i++) begin
				bpa_reg[i] <= bpa_next[i];
			end
			bctl_reg <= bctl_next;
			bstat_reg <= bstat_next;
			tlim_reg <= tlim_next;
			bus_rdata_o <= rdata_next;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			halted_o <= 1'b0;
			shutdown_o <= 1'b0;
			real_mode_o <= 1'b0;
		end else begin
			halted_o <= state_next == rmedb_pkg::ST_HALTED;
			shutdown_o <= state_next == rmedb_pkg::ST_SHUTDOWN;
			real_mode_o <= 1'b1; // RQ6
		end
	end

	assign exc_o = exc_reg;
	assign phys_addr_o = phys_reg;
	assign wake_o = wake_reg;
	assign return_code_pointer_o = rcp_reg;
	assign bus_lock_o = lock_reg;
	assign oper32_o = op32_reg;

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (sys_rst_i);

	sequence seq_stop_taken;
		run && instr_i.valid && instr_i.opcode == rmedb_pkg::OP_STOP && !exc_next.valid
			&& state_next == rmedb_pkg::ST_HALTED;
	endsequence

	sequence seq_halted_idle;
		state_reg == rmedb_pkg::ST_HALTED && !nmi_edge && !float_lvl && !(intr_lvl && if_reg);
	endsequence

	chk_break_vec: assert property (run && instr_i.valid && instr_i.opcode == rmedb_pkg::OP_BREAK
		&& !instr_i.flags[rmedb_pkg::TF_BIT] && !instr_i.lock && !mem_i.valid && exec_hit == '0
		|=> exc_o.valid && exc_o.vector == rmedb_pkg::VEC_BREAK && !exc_o.fault) // RQ1
		else $error("breakpoint opcode did not trap 3");

	chk_step_trap: assert property (run && instr_i.valid && instr_i.flags[rmedb_pkg::TF_BIT]
		|=> exc_o.valid && exc_o.vector == rmedb_pkg::VEC_DEBUG
			&& bstat_reg[rmedb_pkg::BS_STEP_BIT]) // RQ2
		else $error("single step trap missing");

	chk_bp_off: assert property (bctl_reg[rmedb_pkg::NUM_BP-1:0] == '0
		|-> exec_hit == '0 && data_hit == '0) // RQ4
		else $error("disabled breakpoint matched");

	chk_bp_vec: assert property (run && (|exec_hit) && !(|data_hit)
		&& !instr_i.flags[rmedb_pkg::TF_BIT]
		|=> exc_o.valid && exc_o.vector == rmedb_pkg::VEC_DEBUG && exc_o.fault) // RQ5
		else $error("breakpoint match not vectored to 1");

	chk_mode_reset: assert property ($fell(sys_rst_i) |-> !oper32_o ##1 real_mode_o) // RQ6
		else $error("not real mode 16-bit after reset");

	chk_phys_form: assert property (run && mem_i.valid
		|=> phys_addr_o == rmedb_pkg::PHYS_W'(($past(mem_i.seg_val) << 4)
			+ $past(mem_i.ea[15:0]))) // RQ7
		else $error("physical address mismatch");

	chk_seg_over: assert property (run && mem_i.valid && mem_i.seg != rmedb_pkg::SG_STACK
		&& mem_i.ea > rmedb_pkg::SEG_LIMIT && !instr_i.valid && !(|data_hit)
		&& tlim_reg == rmedb_pkg::TLIM_RST
		|=> exc_o.valid && exc_o.vector == rmedb_pkg::VEC_GPROT && exc_o.fault) // RQ10
		else $error("segment overrun not 13");

	chk_stack_over: assert property (run && mem_i.valid && mem_i.seg == rmedb_pkg::SG_STACK
		&& mem_i.ea > rmedb_pkg::SEG_LIMIT && !mem_i.is_push && !instr_i.valid && !(|data_hit)
		|=> exc_o.valid && exc_o.vector == rmedb_pkg::VEC_STACK) // RQ11
		else $error("stack overrun not 12");

	chk_tbl_limit: assert property (run && int_i.valid && !instr_i.valid && !mem_i.valid
		&& vec_outside(int_i.vector, tlim_reg) && !vec_outside(rmedb_pkg::VEC_DFAULT, tlim_reg)
		|=> exc_o.valid && exc_o.vector == rmedb_pkg::VEC_DFAULT) // RQ12
		else $error("table limit fault missing");

	chk_no_pm_vec: assert property (exc_o.valid |-> exc_o.vector != rmedb_pkg::VEC_TSS
		&& exc_o.vector != rmedb_pkg::VEC_NOTP && exc_o.vector != rmedb_pkg::VEC_PAGE) // RQ13
		else $error("protected-mode vector raised");

	chk_halt_hold: assert property (seq_stop_taken |=> seq_halted_idle[*2] |-> halted_o) // RQ16
		else $error("halt released without cause");

	chk_wake_ptr: assert property (state_reg == rmedb_pkg::ST_HALTED
		&& (nmi_edge || float_lvl || (intr_lvl && if_reg))
		|=> wake_o && return_code_pointer_o == $past(rcp_reg)
			&& !halted_o) // RQ17
		else $error("wake pointer wrong");

	chk_sd_enter: assert property (run && mem_i.valid && mem_i.is_push
		&& mem_i.seg == rmedb_pkg::SG_STACK && stack_pointer_i == rmedb_pkg::SP_ONE
		&& !instr_i.valid && !(|data_hit) |=> shutdown_o && !exc_o.valid) // RQ18
		else $error("odd stack wrap did not shut down");

	chk_sd_exit: assert property (state_reg == rmedb_pkg::ST_SHUTDOWN
		&& (tlim_reg < rmedb_pkg::NMI_LIM_MIN || stack_pointer_i <= rmedb_pkg::NMI_SP_MIN)
		|=> shutdown_o) // RQ19
		else $error("shutdown left without room");

	chk_lock_bad: assert property (run && instr_i.valid && instr_i.lock && instr_i.rep
		&& !instr_i.flags[rmedb_pkg::TF_BIT] && !mem_i.valid && exec_hit == '0
		|=> exc_o.valid && exc_o.vector == rmedb_pkg::VEC_INVOP && !bus_lock_o) // RQ20
		else $error("illegal atomic prefix accepted");

endmodule

`default_nettype wire

/* File: logic/rmedb_pkg.sv */
// Constants, types and register map of the real-mode exception and debug unit.
// Assumes a core that reports retiring instructions, memory accesses and
// interrupt dispatches on the same clock.
`default_nettype none

package rmedb_pkg;
	// ****************************************************************
	// Register map and fields
	// ****************************************************************
	localparam int unsigned BUS_AW = 5;
	localparam logic [4:0] REG_BPA0 = 5'h00;
	localparam logic [4:0] REG_BPA1 = 5'h04;
	localparam logic [4:0] REG_BPA2 = 5'h08;
	localparam logic [4:0] REG_BPA3 = 5'h0C;
	localparam logic [4:0] REG_BSTAT = 5'h10;
	localparam logic [4:0] REG_BCTL = 5'h14;
	localparam logic [4:0] REG_TLIM = 5'h18;
	localparam logic [4:0] REG_STATE = 5'h1C;
	localparam int unsigned NUM_BP = 4;
	localparam int unsigned BS_STEP_BIT = 14;
	localparam int unsigned BCTL_TYPE_LSB = 16;
	localparam logic [1:0] BPT_EXEC = 2'h0;
	localparam logic [1:0] BPT_WR = 2'h1;
	localparam logic [1:0] BPT_RW = 2'h3;
	localparam logic [31:0] BCTL_RST = 32'h00000000;
	localparam logic [31:0] BSTAT_RST = 32'h00000000;
	localparam logic [15:0] TLIM_RST = 16'h03FF;
	// ****************************************************************
	// Opcodes, vectors, flags and limits
	// ****************************************************************
	localparam logic [7:0] OP_BREAK = 8'hCC;
	localparam logic [7:0] OP_STOP = 8'hF4;
	localparam logic [7:0] VEC_DEBUG = 8'h01;
	localparam logic [7:0] VEC_BREAK = 8'h03;
	localparam logic [7:0] VEC_INVOP = 8'h06;
	localparam logic [7:0] VEC_DFAULT = 8'h08;
	localparam logic [7:0] VEC_TSS = 8'h0A;
	localparam logic [7:0] VEC_NOTP = 8'h0B;
	localparam logic [7:0] VEC_STACK = 8'h0C;
	localparam logic [7:0] VEC_GPROT = 8'h0D;
	localparam logic [7:0] VEC_PAGE = 8'h0E;
	localparam int unsigned TF_BIT = 8;
	localparam int unsigned IF_BIT = 9;
	localparam logic [31:0] SEG_LIMIT = 32'h0000FFFF;
	localparam logic [3:0] SEG_PAD = 4'h0;
	localparam logic [1:0] VEC_TAIL = 2'h3;
	localparam logic [15:0] NMI_LIM_MIN = 16'h000F;
	localparam logic [15:0] NMI_SP_MIN = 16'h0005;
	localparam logic [15:0] SP_ONE = 16'h0001;
	localparam int unsigned PHYS_W = 20;
	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [2:0] {
		LK_NONE, LK_BIT_MEM, LK_XCHG_MEM, LK_ALU_MEM, LK_UNARY_MEM, LK_OTHER
	} rmedb_lock_cls_t;
	typedef enum logic [1:0] {SG_CODE, SG_DATA, SG_EXTRA, SG_STACK} rmedb_seg_t;
	typedef enum {ST_RUN, ST_HALTED, ST_SHUTDOWN} rmedb_state_t;
	typedef struct packed {
		logic valid;
		logic [7:0] opcode;
		logic [19:0] lin_addr;
		logic [15:0] next_ip;
		logic [15:0] flags;
		logic lock;
		logic rep;
		rmedb_lock_cls_t lock_cls;
		logic opsize_pfx;
	} rmedb_instr_t;
	typedef struct packed {
		logic valid;
		rmedb_seg_t seg;
		logic [15:0] seg_val;
		logic [31:0] ea;
		logic is_word;
		logic is_write;
		logic is_fetch;
		logic is_push;
	} rmedb_mem_t;
	typedef struct packed {
		logic valid;
		logic [7:0] vector;
	} rmedb_int_t;
	typedef struct packed {
		logic valid;
		logic [7:0] vector;
		logic fault;
	} rmedb_exc_t;
endpackage

`default_nettype wire

/* File: tb/rmedb_ext_model.sv */
// Model of the interrupt pins and of the system software memory layout.
// Assumes bench requests change just after a rising clock edge.
`default_nettype none

module rmedb_ext_model (
	input wire logic mclk_i,
	input wire logic nmi_req_i,
	input wire logic intr_req_i,
	input wire logic float_req_i,
	output logic nmi_o,
	output logic intr_o,
	output logic bus_float_n_o,
	output logic [15:0] table_limit_o,
	output logic [19:0] init_base_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************************************
	// Pins and memory layout
	// ****************************************************************
	always @(posedge mclk_i) begin
		nmi_o <= nmi_req_i;
		intr_o <= intr_req_i;
		bus_float_n_o <= ~float_req_i;
	end
	assign table_limit_o = 16'h03FF;
	assign init_base_o = 20'hFFFF0;
endmodule

`default_nettype wire

/* File: tb/rmedb_unit_tb_top.sv */
// Self-checking bench for the real-mode exception and debug unit.
// Assumes the package, the unit and the pin model are compiled first.
`default_nettype none

module rmedb_unit_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************************************
	// Stimulus, checks and scenarios
	// ****************************************************************
	logic mclk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [4:0] addr = '0;
	logic [31:0] wdata = '0;
	logic [31:0] rdata;
	logic wr = 1'b0;
	logic rd = 1'b0;
	rmedb_pkg::rmedb_instr_t ins_v = '0;
	rmedb_pkg::rmedb_mem_t mem_v = '0;
	rmedb_pkg::rmedb_int_t int_v = '0;
	logic [15:0] sp = 16'h0100;
	logic nmi_q = 1'b0;
	logic intr_q = 1'b0;
	logic flt_q = 1'b0;
	logic nmi, intr, flt_n, halted, shut, wake, lock, o32, real_m;
	logic [15:0] tlim_sw;
	logic [15:0] rcp;
	logic [19:0] init;
	logic [19:0] phys;
	rmedb_pkg::rmedb_exc_t exc;
	int fails = 0;
	int comparisons = 0;
	int wakes = 0;
	always #2.5 mclk_i = ~mclk_i;
	rmedb_unit dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .bus_addr_i(addr),
		.bus_wdata_i(wdata), .bus_wr_i(wr), .bus_rd_i(rd), .bus_rdata_o(rdata),
		.instr_i(ins_v), .mem_i(mem_v), .int_i(int_v), .stack_pointer_i(sp), .nmi_i(nmi),
		.intr_i(intr), .bus_float_n_i(flt_n), .exc_o(exc), .phys_addr_o(phys),
		.halted_o(halted), .shutdown_o(shut), .wake_o(wake), .return_code_pointer_o(rcp),
		.bus_lock_o(lock), .oper32_o(o32), .real_mode_o(real_m));
	rmedb_ext_model ext (.mclk_i(mclk_i), .nmi_req_i(nmi_q), .intr_req_i(intr_q),
		.float_req_i(flt_q), .nmi_o(nmi), .intr_o(intr), .bus_float_n_o(flt_n),
		.table_limit_o(tlim_sw), .init_base_o(init));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	always @(negedge mclk_i) begin
		if (wake === 1'b1)
			wakes++;
		if (exc.valid === 1'b1)
			chk(32'(exc.vector inside {8'h0A, 8'h0B, 8'h0E}), 32'h0, "vector");
	end
	task automatic bus_wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk_i);
		wr <= 1'b0;
	endtask
	task automatic bus_rd(input logic [4:0] a, input logic [31:0] exp, input string msg);
		@(posedge mclk_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk_i);
		rd <= 1'b0;
		#1;
		chk(rdata, exp, msg);
	endtask
	task automatic core(input rmedb_pkg::rmedb_instr_t i, input rmedb_pkg::rmedb_mem_t m,
			input rmedb_pkg::rmedb_int_t n);
		@(posedge mclk_i);
		ins_v <= i;
		mem_v <= m;
		int_v <= n;
		@(posedge mclk_i);
		ins_v <= '0;
		mem_v <= '0;
		int_v <= '0;
		#1;
	endtask
	task automatic exp_exc(input logic v, input logic [7:0] vec, input logic f, input string m);
		chk(v ? 32'(exc) : 32'(exc.valid), 32'({v, vec, f}), m);
	endtask
	task automatic wait_st(input logic [1:0] hs, input string msg);
		int n;
		n = 0;
		while ({halted, shut} !== hs && n < 12) begin
			@(posedge mclk_i);
			#1;
			n++;
		end
		chk(32'({halted, shut}), 32'(hs), msg);
		if ({halted, shut} !== hs)
			close_out();
	endtask
	task automatic nmi_pulse();
		@(posedge mclk_i);
		nmi_q <= 1'b1;
		repeat (4) @(posedge mclk_i);
		nmi_q <= 1'b0;
		repeat (4) @(posedge mclk_i);
		#1;
	endtask
	function automatic rmedb_pkg::rmedb_instr_t ins(input logic [7:0] op,
			input logic [15:0] fl, input logic lk, input rmedb_pkg::rmedb_lock_cls_t cl);
		ins = '{1'b1, op, 20'h00000, 16'h0101, fl, lk, 1'b0, cl, 1'b0};
	endfunction
	function automatic rmedb_pkg::rmedb_mem_t mm(input rmedb_pkg::rmedb_seg_t s,
			input logic [31:0] ea, input logic wd, input logic w, input logic ps);
		mm = '{1'b1, s, 16'h1234, ea, wd, w, 1'b0, ps};
	endfunction
	task automatic t_reset();
		chk(32'({real_m, o32}), 32'h2, "mode");
		bus_rd(rmedb_pkg::REG_BCTL, 32'h0, "ctl");
		bus_rd(rmedb_pkg::REG_BSTAT, 32'h0, "stat");
		bus_rd(rmedb_pkg::REG_TLIM, 32'h3FF, "lim");
		bus_wr(rmedb_pkg::REG_STATE, 32'hFFFFFFFF);
		bus_rd(rmedb_pkg::REG_STATE, 32'h4, "state");
		bus_rd(5'h02, 32'h0, "unmapped");
		core(ins(8'h90, 16'h0, 1'b0, rmedb_pkg::LK_NONE), '0, '0);
		exp_exc(1'b0, 8'h00, 1'b0, "off");
		$display("reset test done");
	endtask
	task automatic t_debug();
		rmedb_pkg::rmedb_instr_t i;
		core(ins(rmedb_pkg::OP_BREAK, 16'h0, 1'b0, rmedb_pkg::LK_NONE), '0, '0);
		exp_exc(1'b1, 8'h03, 1'b0, "break");
		i = ins(8'h90, 16'h0100, 1'b0, rmedb_pkg::LK_NONE);
		i.opsize_pfx = 1'b1;
		core(i, '0, '0);
		exp_exc(1'b1, 8'h01, 1'b0, "step");
		chk(32'(o32), 32'h1, "oper32");
		bus_rd(rmedb_pkg::REG_BSTAT, 32'h4000, "stat");
		bus_wr(rmedb_pkg::REG_BSTAT, 32'h4000);
		bus_wr(rmedb_pkg::REG_BPA0, 32'(init));
		bus_wr(rmedb_pkg::REG_BPA1, 32'h12350);
		bus_wr(rmedb_pkg::REG_BCTL, 32'h00040003);
		i = ins(8'h90, 16'h0, 1'b0, rmedb_pkg::LK_NONE);
		i.lin_addr = init;
		core(i, '0, '0);
		exp_exc(1'b1, 8'h01, 1'b1, "exec bp");
		core('0, mm(rmedb_pkg::SG_DATA, 32'h10, 1'b0, 1'b1, 1'b0), '0);
		exp_exc(1'b1, 8'h01, 1'b0, "data bp");
		chk(32'(phys), 32'h12350, "phys");
		bus_wr(rmedb_pkg::REG_BCTL, 32'h000C0002);
		core('0, mm(rmedb_pkg::SG_DATA, 32'h10, 1'b0, 1'b0, 1'b0), '0);
		exp_exc(1'b1, 8'h01, 1'b0, "rw bp");
		bus_rd(rmedb_pkg::REG_BSTAT, 32'h3, "hits");
		bus_wr(rmedb_pkg::REG_BCTL, 32'h0);
		$display("debug test done");
	endtask
	task automatic t_seg();
		rmedb_pkg::rmedb_seg_t sg[5] = '{rmedb_pkg::SG_DATA, rmedb_pkg::SG_EXTRA,
			rmedb_pkg::SG_CODE, rmedb_pkg::SG_STACK, rmedb_pkg::SG_DATA};
		logic [31:0] ea[5] = '{32'hFFFF, 32'hFFFF, 32'h10000, 32'h10000, 32'h10};
		logic [7:0] vec[5] = '{8'h00, 8'h0D, 8'h0D, 8'h0C, 8'h00};
		for (int k = 0; k < 5; k++) begin
			core('0, mm(sg[k], ea[k], k == 1, 1'b0, 1'b0), '0);
			exp_exc(vec[k] != 8'h00, vec[k], vec[k] != 8'h00, "seg");
			if (vec[k] == 8'h00)
				chk(32'(phys), 32'h12340 + 32'(ea[k][15:0]), "phys");
		end
		$display("segment test done");
	endtask
	task automatic t_lock();
		rmedb_pkg::rmedb_instr_t i;
		logic ok;
		for (int k = 0; k < 7; k++) begin
			i = ins(8'h90, 16'h3000, 1'b1, (k == 6) ? rmedb_pkg::LK_ALU_MEM :
				rmedb_pkg::rmedb_lock_cls_t'(k));
			i.rep = (k == 6);
			ok = (k > 0 && k < 5);
			core(i, '0, '0);
			chk(ok ? 32'(exc.valid) : 32'({exc.valid, exc.vector}), ok ? 0 : 32'h106, "lk");
			chk(32'(lock), 32'(ok), "lock");
		end
		$display("lock test done");
	endtask
	task automatic t_shut();
		int n;
		bus_wr(rmedb_pkg::REG_TLIM, 32'h27);
		core('0, '0, '{1'b1, 8'h09});
		exp_exc(1'b0, 8'h00, 1'b0, "in limit");
		core('0, '0, '{1'b1, 8'h0A});
		exp_exc(1'b1, 8'h08, 1'b1, "beyond");
		bus_wr(rmedb_pkg::REG_TLIM, 32'h1F);
		sp <= 16'h0005;
		core('0, '0, '{1'b1, 8'h0A});
		chk(32'(shut), 32'h1, "shut");
		nmi_pulse();
		chk(32'(shut), 32'h1, "sp low");
		@(posedge mclk_i);
		sp <= 16'h0001;
		n = wakes;
		nmi_pulse();
		chk(32'(shut), 32'h1, "sp odd");
		@(posedge mclk_i);
		sp <= 16'h0006;
		nmi_pulse();
		wait_st(2'b00, "nmi exit");
		chk(32'(wakes), 32'(n + 1), "wake");
		@(posedge mclk_i);
		sp <= 16'h0001;
		core('0, mm(rmedb_pkg::SG_STACK, 32'h0, 1'b1, 1'b1, 1'b1), '0);
		chk(32'(shut), 32'h1, "wrap");
		@(posedge mclk_i);
		sp <= 16'h0100;
		nmi_pulse();
		wait_st(2'b00, "exit");
		bus_wr(rmedb_pkg::REG_TLIM, 32'(tlim_sw));
		$display("shutdown test done");
	endtask
	task automatic t_halt();
		rmedb_pkg::rmedb_instr_t i;
		i = ins(rmedb_pkg::OP_STOP, 16'h0, 1'b0, rmedb_pkg::LK_NONE);
		i.next_ip = 16'h1230;
		core(i, '0, '0);
		chk(32'({halted, rcp}), 32'h11230, "halt");
		core(ins(rmedb_pkg::OP_BREAK, 16'h0, 1'b0, rmedb_pkg::LK_NONE), '0, '0);
		exp_exc(1'b0, 8'h00, 1'b0, "ignored");
		intr_q <= 1'b1;
		repeat (8) @(posedge mclk_i);
		#1;
		chk(32'(halted), 32'h1, "masked");
		@(posedge mclk_i);
		flt_q <= 1'b1;
		wait_st(2'b00, "float");
		@(posedge mclk_i);
		flt_q <= 1'b0;
		intr_q <= 1'b0;
		repeat (4) @(posedge mclk_i);
		i.flags = 16'h0200;
		i.next_ip = 16'h4560;
		core(i, '0, '0);
		intr_q <= 1'b1;
		wait_st(2'b00, "intr");
		chk(32'(rcp), 32'h4560, "rcp");
		@(posedge mclk_i);
		intr_q <= 1'b0;
		repeat (4) @(posedge mclk_i);
		i.flags = 16'h0;
		core(i, '0, '0);
		nmi_pulse();
		wait_st(2'b00, "nmi");
		$display("halt test done");
	endtask
	initial begin
		repeat (20) @(posedge mclk_i);
		sys_rst_i <= 1'b0;
		@(posedge mclk_i);
		#1;
		t_reset();
		t_debug();
		t_seg();
		t_lock();
		t_shut();
		t_halt();
		close_out();
	end
endmodule

`default_nettype wire
